// ===== design/opdec_pkg.sv
package opdec_pkg;

    // ------------------------------------------------------------
    // operation codes
    // ------------------------------------------------------------
    typedef enum logic [5:0] {
        OP_NONE                 = 6'h00,
        OP_ADD_PRODUCT_TO_ACC   = 6'h01,
        OP_COPY_PRODUCT_TO_ACC  = 6'h02,
        OP_SUB_PRODUCT_FROM_ACC = 6'h03,
        OP_LOAD_FACTOR_REG      = 6'h04,
        OP_LOAD_FACTOR_ADD_PREV = 6'h05,
        OP_LOAD_FACTOR_MOVE     = 6'h06,
        OP_LOAD_FACTOR_COPY_PROD = 6'h07,
        OP_LOAD_FACTOR_SUB_PREV = 6'h08,
        OP_LOAD_PRODUCT_HIGH    = 6'h09,
        OP_MULT_ACCUMULATE_PROG = 6'h0A,
        OP_MULT_ACCUMULATE_MOVE = 6'h0B,
        OP_MULTIPLY_BY_FACTOR   = 6'h0C,
        OP_MULTIPLY_UNSIGNED    = 6'h0D,
        OP_MULTIPLY_IMMEDIATE   = 6'h0E,
        OP_MULTIPLY_ADD_PREV    = 6'h0F,
        OP_MULTIPLY_SUB_PREV    = 6'h10,
        OP_STORE_PRODUCT_HIGH   = 6'h11,
        OP_STORE_PRODUCT_LOW    = 6'h12,
        OP_SET_PRODUCT_SHIFT    = 6'h13,
        OP_SQUARE_ADD           = 6'h14,
        OP_SQUARE_SUB           = 6'h15,
        OP_JUMP_VIA_ACC         = 6'h16,
        OP_JUMP_ALWAYS          = 6'h17,
        OP_JUMP_AUX_NONZERO     = 6'h18,
        OP_JUMP_FLAG_SET        = 6'h19,
        OP_JUMP_FLAG_CLEAR      = 6'h1A,
        OP_JUMP_ACC_NONNEG      = 6'h1B,
        OP_JUMP_ACC_POSITIVE    = 6'h1C,
        OP_JUMP_IO_PIN_LOW      = 6'h1D,
        OP_JUMP_ON_CARRY        = 6'h1E
    } op_type;

    // ------------------------------------------------------------
    // fixed encodings
    // ------------------------------------------------------------
    localparam logic [15:0] ENC_ADD_PRODUCT = 16'hCE15;
    localparam logic [15:0] ENC_COPY_PRODUCT = 16'hCE14;
    localparam logic [15:0] ENC_SUB_PRODUCT = 16'hCE16;
    localparam logic [13:0] ENC_SET_SHIFT = 14'h3382;
    localparam logic [14:0] ENC_JUMP_ACC = 15'h6712;
    localparam logic [2:0] ENC_MUL_IMM = 3'h5;
    localparam logic [7:0] UB_LOAD_FACTOR = 8'h3C;
    localparam logic [7:0] UB_LOAD_FACTOR_ADD = 8'h3D;
    localparam logic [7:0] UB_LOAD_FACTOR_MOVE = 8'h3F;
    localparam logic [7:0] UB_LOAD_FACTOR_COPY = 8'h3E;
    localparam logic [7:0] UB_LOAD_FACTOR_SUB = 8'h5B;
    localparam logic [7:0] UB_LOAD_PROD_HIGH = 8'h53;
    localparam logic [7:0] UB_MAC_PROG = 8'h5D;
    localparam logic [7:0] UB_MAC_MOVE = 8'h5C;
    localparam logic [7:0] UB_MUL_FACTOR = 8'h38;
    localparam logic [7:0] UB_MUL_UNSIGNED = 8'hCF;
    localparam logic [7:0] UB_MUL_ADD = 8'h3A;
    localparam logic [7:0] UB_MUL_SUB = 8'h3B;
    localparam logic [7:0] UB_STORE_HIGH = 8'h7D;
    localparam logic [7:0] UB_STORE_LOW = 8'h7C;
    localparam logic [7:0] UB_SQUARE_ADD = 8'h39;
    localparam logic [7:0] UB_SQUARE_SUB = 8'h5A;
    localparam logic [7:0] UB_JUMP = 8'hFF;
    localparam logic [7:0] UB_JUMP_AUX = 8'hFB;
    localparam logic [7:0] UB_JUMP_FLAG_SET = 8'hF9;
    localparam logic [7:0] UB_JUMP_FLAG_CLR = 8'hF8;
    localparam logic [7:0] UB_JUMP_NONNEG = 8'hF4;
    localparam logic [7:0] UB_JUMP_POS = 8'hF1;
    localparam logic [7:0] UB_JUMP_IO = 8'hFA;
    localparam logic [7:0] UB_JUMP_CARRY = 8'h5E;

    // ------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------
    localparam int IND_BIT = 7;
    localparam logic [1:0] LEN_ONE = 2'h1;
    localparam logic [1:0] LEN_TWO = 2'h2;
    localparam logic [15:0] RESET_WORD = 16'h0000;

    // ------------------------------------------------------------
    // decoded instruction
    // ------------------------------------------------------------
    typedef struct packed {
        op_type op;
        logic [1:0] length;
        logic indirect;
        logic [6:0] direct_addr;
        logic [6:0] aux_update;
        logic [12:0] immediate;
        logic [1:0] product_shift_sel;
        logic [15:0] target;
        logic is_branch;
        logic known;
    } decoded_type;

    typedef struct packed {
        logic acc_nonneg;
        logic acc_positive;
        logic aux_nonzero;
        logic test_control_flag;
        logic io_pin;
        logic carry;
    } cond_type;

endpackage

// ===== design/opcode_match.sv
`timescale 1ns/10ps
module opcode_match (
    input wire logic [15:0] i_word,
    output opdec_pkg::decoded_type o_dec
);
    import opdec_pkg::*;

    logic [7:0] ub;
    assign ub = i_word[15:8];

    // ------------------------------------------------------------
    // combinational match
    // ------------------------------------------------------------
    always_comb begin
        o_dec = '0;
        o_dec.op = OP_NONE;
        o_dec.length = LEN_ONE;
        o_dec.indirect = i_word[IND_BIT];
        o_dec.direct_addr = i_word[6:0];
        o_dec.aux_update = i_word[6:0];
        o_dec.immediate = i_word[12:0];
        o_dec.product_shift_sel = i_word[1:0];
        o_dec.known = 1'b1;
        // full-word codes win over shorter masked codes sharing 0xCE
        if (i_word == ENC_ADD_PRODUCT) begin
            o_dec.op = OP_ADD_PRODUCT_TO_ACC;
        end else if (i_word == ENC_COPY_PRODUCT) begin
            o_dec.op = OP_COPY_PRODUCT_TO_ACC;
        end else if (i_word == ENC_SUB_PRODUCT) begin
            o_dec.op = OP_SUB_PRODUCT_FROM_ACC;
        end else if (i_word[15:2] == ENC_SET_SHIFT) begin
            o_dec.op = OP_SET_PRODUCT_SHIFT;
        end else if (i_word[15:1] == ENC_JUMP_ACC) begin
            o_dec.op = OP_JUMP_VIA_ACC;
            o_dec.is_branch = 1'b1;
        end else if (i_word[15:13] == ENC_MUL_IMM) begin
            o_dec.op = OP_MULTIPLY_IMMEDIATE;
        end else begin
            unique case (ub)
                UB_LOAD_FACTOR: o_dec.op = OP_LOAD_FACTOR_REG;
                UB_LOAD_FACTOR_ADD: o_dec.op = OP_LOAD_FACTOR_ADD_PREV;
                UB_LOAD_FACTOR_MOVE: o_dec.op = OP_LOAD_FACTOR_MOVE;
                UB_LOAD_FACTOR_COPY: o_dec.op = OP_LOAD_FACTOR_COPY_PROD;
                UB_LOAD_FACTOR_SUB: o_dec.op = OP_LOAD_FACTOR_SUB_PREV;
                UB_LOAD_PROD_HIGH: o_dec.op = OP_LOAD_PRODUCT_HIGH;
                UB_MUL_FACTOR: o_dec.op = OP_MULTIPLY_BY_FACTOR;
                UB_MUL_UNSIGNED: o_dec.op = OP_MULTIPLY_UNSIGNED;
                UB_MUL_ADD: o_dec.op = OP_MULTIPLY_ADD_PREV;
                UB_MUL_SUB: o_dec.op = OP_MULTIPLY_SUB_PREV;
                UB_STORE_HIGH: o_dec.op = OP_STORE_PRODUCT_HIGH;
                UB_STORE_LOW: o_dec.op = OP_STORE_PRODUCT_LOW;
                UB_SQUARE_ADD: o_dec.op = OP_SQUARE_ADD;
                UB_SQUARE_SUB: o_dec.op = OP_SQUARE_SUB;
                UB_MAC_PROG: begin
                    o_dec.op = OP_MULT_ACCUMULATE_PROG;
                    o_dec.length = LEN_TWO;
                end
                UB_MAC_MOVE: begin
                    o_dec.op = OP_MULT_ACCUMULATE_MOVE;
                    o_dec.length = LEN_TWO;
                end
                UB_JUMP: o_dec.op = OP_JUMP_ALWAYS;
                UB_JUMP_AUX: o_dec.op = OP_JUMP_AUX_NONZERO;
                UB_JUMP_FLAG_SET: o_dec.op = OP_JUMP_FLAG_SET;
                UB_JUMP_FLAG_CLR: o_dec.op = OP_JUMP_FLAG_CLEAR;
                UB_JUMP_NONNEG: o_dec.op = OP_JUMP_ACC_NONNEG;
                UB_JUMP_POS: o_dec.op = OP_JUMP_ACC_POSITIVE;
                UB_JUMP_IO: o_dec.op = OP_JUMP_IO_PIN_LOW;
                UB_JUMP_CARRY: o_dec.op = OP_JUMP_ON_CARRY;
                default: o_dec.known = 1'b0;
            endcase
            // two-word branches need bit 7 set, else not ours
            if (o_dec.op inside {OP_JUMP_ALWAYS, OP_JUMP_AUX_NONZERO, OP_JUMP_FLAG_SET,
                    OP_JUMP_FLAG_CLEAR, OP_JUMP_ACC_NONNEG, OP_JUMP_ACC_POSITIVE,
                    OP_JUMP_IO_PIN_LOW, OP_JUMP_ON_CARRY}) begin
                if (i_word[IND_BIT]) begin
                    o_dec.length = LEN_TWO;
                    o_dec.is_branch = 1'b1;
                end else begin
                    o_dec.op = OP_NONE;
                    o_dec.known = 1'b0;
                end
            end
        end
    end
endmodule

// ===== design/mult_branch_opcode_decoder.sv
`timescale 1ns/10ps
module mult_branch_opcode_decoder (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_word_valid,
    input wire logic [15:0] i_word,
    input wire opdec_pkg::cond_type i_cond,
    output opdec_pkg::decoded_type o_dec,
    output logic o_dec_valid,
    output logic o_branch_taken,
    output logic o_need_word
);
    import opdec_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef enum logic [0:0] {
        ST_FIRST = 1'b0,
        ST_SECOND = 1'b1
    } state_type;

    state_type state_q;
    decoded_type match;
    decoded_type held_q;
    decoded_type dec_q;
    logic valid_q;
    logic taken_q;
    logic cond_ok;
    decoded_type final_dec;

    opcode_match u_match (
        .i_word(i_word),
        .o_dec(match)
    );

    // ------------------------------------------------------------
    // sequencing
    // ------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            state_q <= ST_FIRST;
        end else if (i_word_valid) begin
            unique case (state_q)
                ST_FIRST: begin
                    if (match.length == LEN_TWO) begin
                        state_q <= ST_SECOND;
                    end
                end
                ST_SECOND: state_q <= ST_FIRST;
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            held_q <= '0;
        end else if (i_word_valid && state_q == ST_FIRST) begin
            held_q <= match;
        end
    end

    // ------------------------------------------------------------
    // completion and condition
    // ------------------------------------------------------------
    always_comb begin
        final_dec = held_q;
        final_dec.target = i_word;
        unique case (held_q.op)
            OP_JUMP_ALWAYS: cond_ok = 1'b1;
            OP_JUMP_AUX_NONZERO: cond_ok = i_cond.aux_nonzero;
            OP_JUMP_FLAG_SET: cond_ok = i_cond.test_control_flag;
            OP_JUMP_FLAG_CLEAR: cond_ok = !i_cond.test_control_flag;
            OP_JUMP_ACC_NONNEG: cond_ok = i_cond.acc_nonneg;
            OP_JUMP_ACC_POSITIVE: cond_ok = i_cond.acc_positive;
            OP_JUMP_IO_PIN_LOW: cond_ok = !i_cond.io_pin;
            OP_JUMP_ON_CARRY: cond_ok = i_cond.carry;
            default: cond_ok = 1'b0;
        endcase
    end

    // conditions sampled with the second word, the last moment before execute
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            dec_q <= '0;
            valid_q <= 1'b0;
            taken_q <= 1'b0;
        end else begin
            valid_q <= 1'b0;
            taken_q <= 1'b0;
            if (i_word_valid && state_q == ST_SECOND) begin
                dec_q <= final_dec;
                valid_q <= 1'b1;
                taken_q <= cond_ok;
            end else if (i_word_valid && match.length == LEN_ONE) begin
                dec_q <= match;
                valid_q <= 1'b1;
                taken_q <= match.op == OP_JUMP_VIA_ACC;
            end
        end
    end

    assign o_dec = dec_q;
    assign o_dec_valid = valid_q;
    assign o_branch_taken = taken_q;
    assign o_need_word = state_q == ST_SECOND;
endmodule

// ===== dv/opdec_props.sv
`timescale 1ns/10ps
module opdec_props
    import opdec_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_word_valid,
    input wire logic [15:0] i_word,
    input wire decoded_type o_dec,
    input wire logic o_dec_valid,
    input wire logic o_branch_taken,
    input wire logic o_need_word
);
    // ----
    // decode checks
    // ----
    default clocking @(posedge i_clk);
    endclocking
    default disable iff (i_rst);
    logic t;
    logic [7:0] ub;
    // first words only; a second word is raw target data
    assign t = i_word_valid && !o_need_word;
    assign ub = i_word[15:8];
    a_fixed_sub: assert property (t && i_word == 16'hCE16 |=> o_dec_valid && o_dec.op == OP_SUB_PRODUCT_FROM_ACC)
        else $error("fixed product word misdecoded");
    a_factor_move: assert property (t && ub == 8'h3F |=> o_dec.op == OP_LOAD_FACTOR_MOVE && o_dec.length == 2'h1)
        else $error("factor load with move misdecoded");
    a_factor_sub: assert property (t && ub == 8'h5B |=> o_dec_valid && o_dec.op == OP_LOAD_FACTOR_SUB_PREV)
        else $error("factor load with subtract misdecoded");
    a_prod_high: assert property (t && ub == 8'h53 |=> {o_dec.indirect, o_dec.direct_addr} == $past(i_word[7:0]))
        else $error("operand field wrong");
    a_mac_wait: assert property (t && ub inside {8'h5D, 8'h5C} |=> o_need_word && !o_dec_valid)
        else $error("two-word multiply did not wait");
    a_imm_mult: assert property (t && i_word[15:13] == 3'h5 |=> o_dec.immediate == $past(i_word[12:0]))
        else $error("immediate field wrong");
    a_shift_mode: assert property (t && i_word[15:2] == 14'h3382 |=> o_dec.product_shift_sel == $past(i_word[1:0]))
        else $error("shift mode field wrong");
    a_acc_jump: assert property (t && i_word[15:1] == 15'h6712 |=> o_branch_taken && o_dec.length == 2'h1)
        else $error("accumulator jump not taken at once");
    a_always_jump: assert property (t && i_word[15:7] == 9'h1FF ##1 i_word_valid |=> o_branch_taken)
        else $error("unconditional jump not taken");
    a_second_word: assert property (o_need_word && i_word_valid |=> o_dec.target == $past(i_word) && !o_need_word)
        else $error("target not taken from second word");
    cover property (o_branch_taken);
    cover property (o_dec_valid && !o_dec.known);
    cover property (o_dec_valid && o_dec.length == 2'h2 && !o_branch_taken);
endmodule

bind mult_branch_opcode_decoder opdec_props u_props (.i_clk(i_clk), .i_rst(i_rst), .i_word_valid(i_word_valid),
    .i_word(i_word), .o_dec(o_dec), .o_dec_valid(o_dec_valid), .o_branch_taken(o_branch_taken),
    .o_need_word(o_need_word));

// ===== dv/prog_mem_model.sv
`timescale 1ns/10ps
module prog_mem_model (
    input wire logic i_clk,
    output logic o_word_valid,
    output logic [15:0] o_word
);
    // ----
    // word source
    // ----
    initial begin
        o_word_valid = 1'b0;
        o_word = 16'h5A5A;
    end
    // word held from falling edge through the taking edge
    task automatic fetch(input logic [15:0] w);
        @(negedge i_clk);
        o_word_valid = 1'b1;
        o_word = w;
        @(posedge i_clk);
    endtask
    // released bus shows the inverse, never a stale word
    task automatic idle();
        @(negedge i_clk);
        o_word_valid = 1'b0;
        o_word = ~o_word;
        @(posedge i_clk);
    endtask
endmodule

// ===== dv/tb_mult_branch_opcode_decoder.sv
`timescale 1ns/10ps
module tb_mult_branch_opcode_decoder;
    import opdec_pkg::*;
    logic i_clk;
    logic i_rst;
    logic i_word_valid;
    logic [15:0] i_word;
    cond_type i_cond;
    decoded_type o_dec;
    logic o_dec_valid;
    logic o_branch_taken;
    logic o_need_word;
    int errors;
    int checked;
    int cycles;
    logic [31:0] seed;
    logic [15:0] corner [$] = '{16'hCE15, 16'hCE14, 16'hCE16, 16'h3C00, 16'h3D80, 16'h3F7F, 16'h3EAA,
        16'h5B01, 16'h5312, 16'h5D05, 16'h5C85, 16'h3811, 16'hCF22, 16'hA000, 16'hBFFF,
        16'h3A00, 16'h3B80, 16'h7D7F, 16'h7C00, 16'hCE08, 16'hCE0B, 16'h3933, 16'h5A44,
        16'hCE24, 16'hCE25, 16'hFF80, 16'hFB81, 16'hF9FF, 16'hF880, 16'hF480, 16'hF180,
        16'hFA80, 16'h5E80, 16'hFF00, 16'hF97F, 16'hCE17, 16'h0000};
    mult_branch_opcode_decoder DUT (.i_clk(i_clk), .i_rst(i_rst), .i_word_valid(i_word_valid), .i_word(i_word),
        .i_cond(i_cond), .o_dec(o_dec), .o_dec_valid(o_dec_valid), .o_branch_taken(o_branch_taken),
        .o_need_word(o_need_word));
    prog_mem_model mem (.i_clk(i_clk), .o_word_valid(i_word_valid), .o_word(i_word));
    // ----
    // clock, timeout, expectations
    // ----
    initial begin
        i_clk = 1'b0;
        forever #12.5 i_clk = ~i_clk;
    end
    // sequence needs about 700 cycles
    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 4000) begin
            errors++;
            report_and_stop();
        end
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic op_type exp_op(input logic [15:0] w);
        if (w == 16'hCE15) return OP_ADD_PRODUCT_TO_ACC;
        if (w == 16'hCE14) return OP_COPY_PRODUCT_TO_ACC;
        if (w == 16'hCE16) return OP_SUB_PRODUCT_FROM_ACC;
        if (w[15:2] == 14'h3382) return OP_SET_PRODUCT_SHIFT;
        if (w[15:1] == 15'h6712) return OP_JUMP_VIA_ACC;
        if (w[15:13] == 3'h5) return OP_MULTIPLY_IMMEDIATE;
        case (w[15:8])
            8'h3C: return OP_LOAD_FACTOR_REG;
            8'h3D: return OP_LOAD_FACTOR_ADD_PREV;
            8'h3F: return OP_LOAD_FACTOR_MOVE;
            8'h3E: return OP_LOAD_FACTOR_COPY_PROD;
            8'h5B: return OP_LOAD_FACTOR_SUB_PREV;
            8'h53: return OP_LOAD_PRODUCT_HIGH;
            8'h5D: return OP_MULT_ACCUMULATE_PROG;
            8'h5C: return OP_MULT_ACCUMULATE_MOVE;
            8'h38: return OP_MULTIPLY_BY_FACTOR;
            8'hCF: return OP_MULTIPLY_UNSIGNED;
            8'h3A: return OP_MULTIPLY_ADD_PREV;
            8'h3B: return OP_MULTIPLY_SUB_PREV;
            8'h7D: return OP_STORE_PRODUCT_HIGH;
            8'h7C: return OP_STORE_PRODUCT_LOW;
            8'h39: return OP_SQUARE_ADD;
            8'h5A: return OP_SQUARE_SUB;
            default: ;
        endcase
        if (!w[7]) return OP_NONE;
        case (w[15:8])
            8'hFF: return OP_JUMP_ALWAYS;
            8'hFB: return OP_JUMP_AUX_NONZERO;
            8'hF9: return OP_JUMP_FLAG_SET;
            8'hF8: return OP_JUMP_FLAG_CLEAR;
            8'hF4: return OP_JUMP_ACC_NONNEG;
            8'hF1: return OP_JUMP_ACC_POSITIVE;
            8'hFA: return OP_JUMP_IO_PIN_LOW;
            8'h5E: return OP_JUMP_ON_CARRY;
            default: return OP_NONE;
        endcase
    endfunction
    function automatic logic exp_taken(input op_type op, input cond_type c);
        case (op)
            OP_JUMP_VIA_ACC, OP_JUMP_ALWAYS: return 1'b1;
            OP_JUMP_AUX_NONZERO: return c.aux_nonzero;
            OP_JUMP_FLAG_SET: return c.test_control_flag;
            OP_JUMP_FLAG_CLEAR: return !c.test_control_flag;
            OP_JUMP_ACC_NONNEG: return c.acc_nonneg;
            OP_JUMP_ACC_POSITIVE: return c.acc_positive;
            OP_JUMP_IO_PIN_LOW: return !c.io_pin;
            OP_JUMP_ON_CARRY: return c.carry;
            default: return 1'b0;
        endcase
    endfunction
    // ----
    // drivers and compares
    // ----
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic send(input logic [15:0] w, input logic [5:0] c);
        fork
            mem.fetch(w);
            begin
                @(negedge i_clk);
                i_cond = c;
            end
        join
        #1;
    endtask
    task automatic rst_chk();
        chk("rst_dec", 16'h1, 16'(o_dec === '0));
        chk("rst_flags", 16'h0, 16'({o_dec_valid, o_branch_taken, o_need_word}));
    endtask
    task automatic run_word(input logic [15:0] w);
        op_type op;
        logic two;
        logic [15:0] tgt;
        op = exp_op(w);
        two = op inside {OP_MULT_ACCUMULATE_PROG, OP_MULT_ACCUMULATE_MOVE, [OP_JUMP_ALWAYS:OP_JUMP_ON_CARRY]};
        seed = lfsr(seed);
        tgt = seed[31:16];
        send(w, seed[5:0]);
        if (two) begin
            chk("need_word", 16'h4, 16'({o_need_word, o_dec_valid, o_branch_taken}));
            seed = lfsr(seed);
            send(tgt, seed[5:0]);
            chk("target", tgt, o_dec.target);
            chk("aux_update", 16'(w[6:0]), 16'(o_dec.aux_update));
        end else begin
            chk("operand", 16'(w[7:0]), 16'({o_dec.indirect, o_dec.direct_addr}));
        end
        chk("valid", 16'h0, 16'({!o_dec_valid, o_need_word}));
        chk("op", 16'(op), 16'(o_dec.op));
        chk("length", two ? 16'h2 : 16'h1, 16'(o_dec.length));
        chk("taken", 16'(exp_taken(op, i_cond)), 16'(o_branch_taken));
        chk("known", 16'(op != OP_NONE), 16'(o_dec.known));
        chk("is_branch", 16'(op inside {OP_JUMP_VIA_ACC, [OP_JUMP_ALWAYS:OP_JUMP_ON_CARRY]}), 16'(o_dec.is_branch));
        if (op == OP_MULTIPLY_IMMEDIATE)
            chk("immediate", 16'(w[12:0]), 16'(o_dec.immediate));
        if (op == OP_SET_PRODUCT_SHIFT)
            chk("shift_sel", 16'(w[1:0]), 16'(o_dec.product_shift_sel));
    endtask
    task automatic report_and_stop();
        if (errors == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial begin
        errors = 0;
        checked = 0;
        cycles = 0;
        seed = 32'h19BE;
        i_rst = 1'b1;
        i_cond = '0;
        repeat (10) @(posedge i_clk);
        #1;
        rst_chk();
        @(negedge i_clk);
        i_rst = 1'b0;
        repeat (2) foreach (corner[k]) run_word(corner[k]);
        // reset between the two words of a jump drops the pending word
        send(16'hFF80, 6'h3F);
        @(negedge i_clk);
        i_rst = 1'b1;
        @(posedge i_clk);
        #1;
        rst_chk();
        mem.idle();
        @(negedge i_clk);
        i_rst = 1'b0;
        run_word(16'h1234);
        repeat (500) begin
            seed = lfsr(seed);
            if (seed[3:0] == 4'h0)
                mem.idle();
            run_word(seed[4] ? {corner[seed[9:5] % 37][15:8], seed[27:20]} : seed[31:16]);
        end
        report_and_stop();
    end
endmodule
